//--- port_e_pkg.sv
// Constants, field layout and carrier types of the port E block
// ============================================================
package port_e_pkg;
  localparam int PIN_COUNT = 3;
  localparam int ADDR_W = 12;
  // Register indices; byte address is four times the index
  localparam logic [9:0] PORT_D_IDX = 10'h008;
  localparam logic [9:0] PIN_DATA_IDX = 10'h009;
  localparam logic [9:0] DIR_IDX = 10'h089;
  localparam logic [9:0] ANALOG_IDX = 10'h09f;
  // Direction register fields
  localparam int IN_FULL_BIT = 7;
  localparam int OUT_FULL_BIT = 6;
  localparam int OVERRUN_BIT = 5;
  localparam int SLAVE_SEL_BIT = 4;
  localparam int READ_PIN = 0;
  localparam int WRITE_PIN = 1;
  localparam int SELECT_PIN = 2;
  // Reset values
  localparam logic [2:0] DIR_RESET = 3'h7;
  localparam logic [2:0] ANALOG_RESET = 3'h0;
  localparam logic [2:0] LATCH_RESET = 3'h0;
  localparam logic [7:0] PORT_D_RESET = 8'h00;
  // Configuration code that makes all three pins digital
  localparam logic [2:0] ALL_DIGITAL = 3'h7;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;
endpackage : port_e_pkg

//--- port_e_pin_cell.sv
// One port E pin: driver enable and read-back value
`timescale 1ns/1ns
module port_e_pin_cell (
  input wire logic dir_in_i,
  input wire logic slave_mode_i,
  input wire logic analog_i,
  input wire logic pin_i,
  output logic drive_o,
  output logic read_o
);
  // Driver follows direction even for analog pins
  assign drive_o = !dir_in_i && !slave_mode_i;
  assign read_o = analog_i ? 1'b0 : pin_i;
endmodule : port_e_pin_cell

//--- port_e_strobe_edge.sv
// Start and end detection of a qualified parallel slave strobe
`timescale 1ns/1ns
module port_e_strobe_edge (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic active_i,
  output logic start_o,
  output logic end_o
);
  logic active_reg;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      active_reg <= 1'b0;
    end else begin
      active_reg <= active_i;
    end
  end
  assign start_o = active_i && !active_reg;
  assign end_o = !active_i && active_reg;
endmodule : port_e_strobe_edge

//--- port_e_io.sv
// Port E pins, direction and slave status, analog select, over APB
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
module port_e_io (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire port_e_pkg::apb_req_t apb_req_i,
  output port_e_pkg::apb_rsp_t apb_rsp_o,
  input wire logic [2:0] e_pin_i,
  output logic [2:0] e_pin_o,
  output logic [2:0] e_pin_oe_o,
  input wire logic [7:0] port_d_bus_i,
  output logic [7:0] port_d_bus_o,
  output logic port_d_bus_oe_o,
  output logic [7:0] port_d_in_latch_o
);

  // ============================================================
  // Register state
  logic [2:0] pin_latch_reg;
  logic [2:0] pin_latch_next;
  logic [2:0] dir_reg;
  logic [2:0] dir_next;
  logic slave_mode_reg;
  logic slave_mode_next;
  logic in_full_reg;
  logic in_full_next;
  logic out_full_reg;
  logic out_full_next;
  logic overrun_reg;
  logic overrun_next;
  logic [2:0] analog_cfg_reg;
  logic [2:0] analog_cfg_next;
  logic [7:0] d_out_latch_reg;
  logic [7:0] d_out_latch_next;
  logic [7:0] d_in_latch_reg;
  logic [7:0] d_in_latch_next;
  port_e_pkg::apb_rsp_t rsp_reg;
  port_e_pkg::apb_rsp_t rsp_next;
  logic [2:0] pin_oe_reg;
  logic d_oe_reg;

  // ============================================================
  // APB decode
  // A transfer waits one cycle in the access phase; the write and
  // the read side effects happen on the edge that sees pready high.
  wire access_w = apb_req_i.psel && apb_req_i.penable;
  wire answer_w = access_w && !rsp_reg.pready;
  wire commit_w = access_w && rsp_reg.pready;
  wire [9:0] idx_w = apb_req_i.paddr[11:2];
  wire hit_pin_w = (idx_w == port_e_pkg::PIN_DATA_IDX);
  wire hit_dir_w = (idx_w == port_e_pkg::DIR_IDX);
  wire hit_ana_w = (idx_w == port_e_pkg::ANALOG_IDX);
  wire hit_d_w = (idx_w == port_e_pkg::PORT_D_IDX);
  wire mapped_w = hit_pin_w || hit_dir_w || hit_ana_w || hit_d_w;
  wire wr_w = commit_w && apb_req_i.pwrite && mapped_w;
  wire rd_w = commit_w && !apb_req_i.pwrite && mapped_w;
  wire [7:0] wdata_w = apb_req_i.pwdata[7:0];

  // ============================================================
  // Pin cells
  logic [2:0] drive_w;
  logic [2:0] pin_read_w;
  // Configuration applies to all three pins together
  wire analog_w = (analog_cfg_reg != port_e_pkg::ALL_DIGITAL);
  genvar gi;
  generate
    for (gi = 0; gi < port_e_pkg::PIN_COUNT; gi++) begin : g_pin
      port_e_pin_cell u_cell (
        .dir_in_i(dir_reg[gi]),
        .slave_mode_i(slave_mode_reg),
        .analog_i(analog_w),
        .pin_i(e_pin_i[gi]),
        .drive_o(drive_w[gi]),
        .read_o(pin_read_w[gi])
      );
    end
  endgenerate

  // ============================================================
  // Parallel slave strobes
  // Strobes are taken from raw pin levels; with analog selected
  // they still work, so software need not make the pins digital first.
  wire sel_w = !e_pin_i[port_e_pkg::SELECT_PIN];
  wire ext_rd_w = slave_mode_reg && sel_w
    && !e_pin_i[port_e_pkg::READ_PIN];
  wire ext_wr_w = slave_mode_reg && sel_w
    && !e_pin_i[port_e_pkg::WRITE_PIN];
  logic rd_start_w;
  logic rd_end_w;
  logic wr_start_w;
  logic wr_end_w;
  port_e_strobe_edge u_rd_edge (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .active_i(ext_rd_w),
    .start_o(rd_start_w),
    .end_o(rd_end_w)
  );
  port_e_strobe_edge u_wr_edge (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .active_i(ext_wr_w),
    .start_o(wr_start_w),
    .end_o(wr_end_w)
  );
  wire d_rd_w = rd_w && hit_d_w;
  wire d_wr_w = wr_w && hit_d_w;

  // ============================================================
  // Next values of the port registers
  assign pin_latch_next = (wr_w && hit_pin_w)
    ? wdata_w[2:0] : pin_latch_reg;
  assign dir_next = (wr_w && hit_dir_w) ? wdata_w[2:0] : dir_reg;
  assign slave_mode_next = (wr_w && hit_dir_w)
    ? wdata_w[port_e_pkg::SLAVE_SEL_BIT] : slave_mode_reg;
  assign analog_cfg_next = (wr_w && hit_ana_w)
    ? wdata_w[2:0] : analog_cfg_reg;
  assign d_out_latch_next = d_wr_w ? wdata_w : d_out_latch_reg;
  assign d_in_latch_next = wr_start_w ? port_d_bus_i
    : d_in_latch_reg;

  // Input full: set at end of an external write, which wins over
  // a clear from a port D read in the same cycle
  assign in_full_next = !slave_mode_reg ? 1'b0
    : wr_end_w ? 1'b1
    : d_rd_w ? 1'b0 : in_full_reg;
  // Output full: firmware write sets it, a read start clears it
  assign out_full_next = !slave_mode_reg ? 1'b0
    : d_wr_w ? 1'b1
    : rd_start_w ? 1'b0 : out_full_reg;
  // Overrun is software writable; the hardware set wins
  assign overrun_next = (wr_start_w && in_full_reg) ? 1'b1
    : (wr_w && hit_dir_w) ? wdata_w[port_e_pkg::OVERRUN_BIT]
    : overrun_reg;

  // ============================================================
  // Read data
  wire [7:0] dir_view_w = {in_full_reg, out_full_reg, overrun_reg,
    slave_mode_reg, 1'b0, dir_reg};
  wire [7:0] rsel_w =
    hit_pin_w ? {5'h00, pin_read_w} :
    hit_dir_w ? dir_view_w :
    hit_ana_w ? {5'h00, analog_cfg_reg} :
    hit_d_w ? d_in_latch_reg : 8'h00;
  always_comb begin
    rsp_next = '0;
    if (answer_w) begin
      rsp_next.pready = 1'b1;
      rsp_next.pslverr = !mapped_w;
      rsp_next.prdata = apb_req_i.pwrite ? 32'h0000_0000
        : {24'h00_0000, rsel_w};
    end
  end

  // ============================================================
  // Registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_latch_reg <= port_e_pkg::LATCH_RESET;
      dir_reg <= port_e_pkg::DIR_RESET;
      slave_mode_reg <= 1'b0;
      analog_cfg_reg <= port_e_pkg::ANALOG_RESET;
      in_full_reg <= 1'b0;
      out_full_reg <= 1'b0;
      overrun_reg <= 1'b0;
      d_out_latch_reg <= port_e_pkg::PORT_D_RESET;
      d_in_latch_reg <= port_e_pkg::PORT_D_RESET;
    end else begin
      pin_latch_reg <= pin_latch_next;
      dir_reg <= dir_next;
      slave_mode_reg <= slave_mode_next;
      analog_cfg_reg <= analog_cfg_next;
      in_full_reg <= in_full_next;
      out_full_reg <= out_full_next;
      overrun_reg <= overrun_next;
      d_out_latch_reg <= d_out_latch_next;
      d_in_latch_reg <= d_in_latch_next;
    end
  end

  // Output flops; enables follow their causes by one cycle
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_reg <= '0;
      pin_oe_reg <= 3'h0;
      d_oe_reg <= 1'b0;
    end else begin
      rsp_reg <= rsp_next;
      pin_oe_reg <= drive_w;
      d_oe_reg <= ext_rd_w;
    end
  end

  assign apb_rsp_o = rsp_reg;
  assign e_pin_o = pin_latch_reg;
  assign e_pin_oe_o = pin_oe_reg;
  assign port_d_bus_o = d_out_latch_reg;
  assign port_d_bus_oe_o = d_oe_reg;
  assign port_d_in_latch_o = d_in_latch_reg;

  // ============================================================
  // Checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_pin_drive_rule: assert property (
    ##1 e_pin_oe_o == (~$past(dir_reg) & {3{!$past(slave_mode_reg)}}))
    else $error("pin driver enable does not follow direction and mode");

  a_analog_reads_zero: assert property (
    (answer_w && !apb_req_i.pwrite && hit_pin_w && analog_w)
      |=> apb_rsp_o.prdata == 32'h0000_0000)
    else $error("analog pin did not read as zero");

  a_pin_read_level: assert property (
    (answer_w && !apb_req_i.pwrite && hit_pin_w && !analog_w)
      |=> apb_rsp_o.prdata[2:0] == $past(e_pin_i))
    else $error("port read did not return pin levels");

  a_latch_write: assert property (
    (wr_w && hit_pin_w) |=> e_pin_o == $past(wdata_w[2:0]))
    else $error("port write did not reach the latch");

  a_full_flags_off: assert property (
    !slave_mode_reg |=> !in_full_reg && !out_full_reg)
    else $error("full flag set outside slave mode");

  a_in_full_set: assert property (
    (slave_mode_reg && wr_end_w) |=> in_full_reg)
    else $error("input full not set after external write");

  a_overrun_set: assert property (
    (wr_start_w && in_full_reg) |=> overrun_reg [*2])
    else $error("overrun not set on write while full");

  a_out_full_clear: assert property (
    (rd_start_w && !d_wr_w) |=> !out_full_reg)
    else $error("output full not cleared on external read");

  a_deselect_ignore: assert property (
    e_pin_i[port_e_pkg::SELECT_PIN] |=> !port_d_bus_oe_o)
    else $error("port D driven while deselected");

  a_read_drives_bus: assert property (
    ext_rd_w [*2] |-> port_d_bus_oe_o)
    else $error("port D not driven during external read");

  a_capture_write: assert property (
    wr_start_w |=> port_d_in_latch_o == $past(port_d_bus_i))
    else $error("bus data not captured on external write");

  a_dir_reserved: assert property (
    (answer_w && !apb_req_i.pwrite && hit_dir_w)
      |=> apb_rsp_o.prdata[3] == 1'b0 && apb_rsp_o.prdata[31:8] == '0)
    else $error("unimplemented direction bit read non-zero");

  a_answer_one_wait: assert property (
    (access_w && !rsp_reg.pready) |=> apb_rsp_o.pready ##1 !apb_rsp_o.pready)
    else $error("APB answer not one wait state wide");

  // ============================================================
  // Register and flag bookkeeping

  a_ready_idle: assert property (
    !access_w |=> !apb_rsp_o.pready)
    else $error("APB answer without an access phase");

  a_unmapped_error: assert property (
    (answer_w && !mapped_w)
      |=> apb_rsp_o.pslverr && apb_rsp_o.prdata == 32'h0000_0000)
    else $error("unmapped index not refused");

  a_write_reads_zero: assert property (
    (answer_w && apb_req_i.pwrite)
      |=> apb_rsp_o.prdata == 32'h0000_0000)
    else $error("write answer carried data");

  a_pin_upper_zero: assert property (
    (answer_w && !apb_req_i.pwrite && hit_pin_w)
      |=> apb_rsp_o.prdata[31:3] == 29'h0)
    else $error("port data read set bits above the pins");

  a_dir_read_back: assert property (
    (answer_w && !apb_req_i.pwrite && hit_dir_w)
      |=> apb_rsp_o.prdata[2:0] == $past(dir_reg))
    else $error("direction bits read back wrong");

  a_dir_write: assert property (
    (wr_w && hit_dir_w)
      |=> dir_reg == $past(apb_req_i.pwdata[2:0]))
    else $error("direction write not taken");

  a_mode_write: assert property (
    (wr_w && hit_dir_w) |=> slave_mode_reg
      == $past(apb_req_i.pwdata[port_e_pkg::SLAVE_SEL_BIT]))
    else $error("mode select write not taken");

  a_analog_write: assert property (
    (wr_w && hit_ana_w)
      |=> analog_cfg_reg == $past(apb_req_i.pwdata[2:0]))
    else $error("analog configuration write not taken");

  a_input_no_drive: assert property (
    (dir_reg != 3'h0) |=> (e_pin_oe_o & $past(dir_reg)) == 3'h0)
    else $error("input pin driven");

  a_slave_no_drive: assert property (
    slave_mode_reg |=> e_pin_oe_o == 3'h0)
    else $error("pin driven in slave mode");

  a_mode_off_quiet: assert property (
    !slave_mode_reg |=> !port_d_bus_oe_o)
    else $error("port D driven outside slave mode");

  a_latch_hold: assert property (
    !(wr_w && hit_pin_w) |=> $stable(e_pin_o))
    else $error("pin latch changed without a write");

  a_in_latch_hold: assert property (
    !wr_start_w |=> $stable(port_d_in_latch_o))
    else $error("input latch changed without an external write");

  a_in_full_hold: assert property (
    (slave_mode_reg && in_full_reg && !d_rd_w) |=> in_full_reg)
    else $error("input full cleared without a port D read");

  a_in_full_clear: assert property (
    (slave_mode_reg && d_rd_w && !wr_end_w) |=> !in_full_reg)
    else $error("input full not cleared by port D read");

  a_out_full_set: assert property (
    (slave_mode_reg && d_wr_w) |=> out_full_reg)
    else $error("output full not set by firmware write");

  a_out_full_low: assert property (
    (!out_full_reg && !d_wr_w) |=> !out_full_reg)
    else $error("output full rose without a firmware write");

  a_overrun_hold: assert property (
    (!wr_start_w && !(wr_w && hit_dir_w)) |=> $stable(overrun_reg))
    else $error("overrun flag changed on its own");

endmodule : port_e_io

//--- psp_host_model.sv
// Model of the external microprocessor on the strobe pins and data bus
`timescale 1ns/1ns
module psp_host_model (
  input wire logic sys_clk_i,
  input wire logic [7:0] dev_bus_i,
  input wire logic dev_bus_oe_i,
  output logic [2:0] strobe_o,
  output logic [7:0] bus_o
);
  // ============================================================
  // Strobe cycles
  initial begin
    strobe_o = 3'h7;
    bus_o = 8'h00;
  end
  // Strobes are held three cycles; the device samples them synchronously
  task automatic cycle(input logic sel, input logic wr, input logic [7:0] d,
                       output logic [8:0] got);
    @(posedge sys_clk_i);
    strobe_o <= {sel, ~wr, wr};
    bus_o <= d;
    repeat (3) @(posedge sys_clk_i);
    got = {dev_bus_oe_i, dev_bus_i};
    strobe_o <= 3'h7;
    // Released bus shows the inverse so a stale byte cannot pass
    bus_o <= ~d;
  endtask : cycle
  task automatic set_levels(input logic [2:0] lv);
    @(posedge sys_clk_i);
    strobe_o <= lv;
  endtask : set_levels
endmodule : psp_host_model

//--- port_e_io_tb.sv
// Self-checking bench of the port E block with an external host model
`timescale 1ns/1ns
module port_e_io_tb;
  logic sys_clk_i;
  logic rst_n_i;
  port_e_pkg::apb_req_t req;
  port_e_pkg::apb_rsp_t rsp;
  logic [2:0] pin_o, pin_oe, host_pins, pin_wire;
  logic [7:0] bus_d, bus_h, in_latch;
  logic bus_oe;
  logic [32:0] expq[$];
  int failures, n_compared;
  // Driven pins win; undriven pins show the host's level
  assign pin_wire = (pin_oe & pin_o) | (~pin_oe & host_pins);
  port_e_io port_e_io_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .apb_req_i(req), .apb_rsp_o(rsp), .e_pin_i(pin_wire), .e_pin_o(pin_o),
    .e_pin_oe_o(pin_oe), .port_d_bus_i(bus_h), .port_d_bus_o(bus_d),
    .port_d_bus_oe_o(bus_oe), .port_d_in_latch_o(in_latch));
  psp_host_model psp_host_model_i (.sys_clk_i(sys_clk_i), .dev_bus_i(bus_d),
    .dev_bus_oe_i(bus_oe), .strobe_o(host_pins), .bus_o(bus_h));
  // ============================================================
  // Checking and closing
  task automatic check(input string what, input logic [32:0] seen,
                       input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge sys_clk_i) begin
    if (req.psel && req.penable && rsp.pready === 1'b1) begin
      check("apb answer", {rsp.pslverr, rsp.prdata}, expq.pop_front());
    end
  end
  // ============================================================
  // Bus master
  task automatic apb(input logic w, input logic [9:0] idx,
                     input logic [7:0] d, input logic [32:0] exp);
    int n;
    expq.push_back(exp);
    @(posedge sys_clk_i);
    req <= '{1'b1, 1'b0, w, {idx, 2'b00}, {24'h0, d}};
    @(posedge sys_clk_i);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) begin
      failures++;
      report_and_stop();
    end
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 33'h0);
  endtask : wr
  task automatic rd(input logic [9:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00, {25'h0, e});
  endtask : rd
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  // ============================================================
  // Scenarios
  initial begin
    logic [2:0] p;
    logic [7:0] b, c;
    logic [8:0] got;
    rst_n_i = 1'b0;
    req = '0;
    void'($urandom(32'h3b22));
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd(port_e_pkg::DIR_IDX, 8'h07);
    rd(port_e_pkg::ANALOG_IDX, 8'h00);
    rd(port_e_pkg::PIN_DATA_IDX, 8'h00);
    apb(1'b0, 10'h3ff, 8'h00, {1'b1, 32'h0});
    $display("test reset done");
    wr(port_e_pkg::ANALOG_IDX, 8'h07);
    wr(port_e_pkg::DIR_IDX, 8'h08);
    rd(port_e_pkg::DIR_IDX, 8'h00);
    b = 8'($urandom);
    wr(port_e_pkg::PIN_DATA_IDX, b);
    repeat (2) @(posedge sys_clk_i);
    check("pin enable", {30'h0, pin_oe}, 33'h7);
    check("pin latch", {30'h0, pin_o}, {30'h0, b[2:0]});
    rd(port_e_pkg::PIN_DATA_IDX, {5'h0, b[2:0]});
    wr(port_e_pkg::DIR_IDX, 8'h07);
    p = 3'($urandom);
    psp_host_model_i.set_levels(p);
    repeat (3) @(posedge sys_clk_i);
    check("pin enable", {30'h0, pin_oe}, 33'h0);
    rd(port_e_pkg::PIN_DATA_IDX, {5'h0, p});
    wr(port_e_pkg::PIN_DATA_IDX, {5'h0, p | 3'h2});
    wr(port_e_pkg::DIR_IDX, 8'h00);
    repeat (2) @(posedge sys_clk_i);
    check("rmw latch", {30'h0, pin_o}, {30'h0, p | 3'h2});
    wr(port_e_pkg::DIR_IDX, 8'h07);
    wr(port_e_pkg::ANALOG_IDX, 8'h06);
    rd(port_e_pkg::PIN_DATA_IDX, 8'h00);
    wr(port_e_pkg::ANALOG_IDX, 8'h07);
    psp_host_model_i.set_levels(3'h7);
    $display("test gpio done");
    wr(port_e_pkg::DIR_IDX, 8'hd7);
    rd(port_e_pkg::DIR_IDX, 8'h17);
    b = 8'($urandom);
    c = 8'($urandom);
    psp_host_model_i.cycle(1'b0, 1'b1, b, got);
    check("in latch", {25'h0, in_latch}, {25'h0, b});
    rd(port_e_pkg::DIR_IDX, 8'h97);
    psp_host_model_i.cycle(1'b0, 1'b1, c, got);
    rd(port_e_pkg::DIR_IDX, 8'hb7);
    rd(port_e_pkg::PORT_D_IDX, c);
    rd(port_e_pkg::DIR_IDX, 8'h37);
    psp_host_model_i.cycle(1'b1, 1'b1, ~c, got);
    check("in latch", {25'h0, in_latch}, {25'h0, c});
    rd(port_e_pkg::DIR_IDX, 8'h37);
    wr(port_e_pkg::PORT_D_IDX, b);
    rd(port_e_pkg::DIR_IDX, 8'h77);
    psp_host_model_i.cycle(1'b1, 1'b0, 8'h00, got);
    check("deselected read", {32'h0, got[8]}, 33'h0);
    psp_host_model_i.cycle(1'b0, 1'b0, 8'h00, got);
    check("host read", {24'h0, got}, {25'h1, b});
    rd(port_e_pkg::DIR_IDX, 8'h37);
    check("pin enable", {30'h0, pin_oe}, 33'h0);
    $display("test slave done");
    psp_host_model_i.cycle(1'b0, 1'b1, b, got);
    wr(port_e_pkg::DIR_IDX, 8'h27);
    rd(port_e_pkg::DIR_IDX, 8'h27);
    wr(port_e_pkg::DIR_IDX, 8'h07);
    rd(port_e_pkg::DIR_IDX, 8'h07);
    $display("test mode off done");
    report_and_stop();
  end
endmodule : port_e_io_tb
